// >>> hcic_pkg.sv
// Constants shared by the identity, retry and compare-swap register group.
package hcic_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_VERSION = 8'h00;
    localparam logic [7:0] ADDR_ROM     = 8'h04;
    localparam logic [7:0] ADDR_RETRY   = 8'h08;
    localparam logic [7:0] ADDR_SWDATA  = 8'h0c;
    localparam logic [7:0] ADDR_SWCMP   = 8'h10;
    localparam logic [7:0] ADDR_SWCTRL  = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PRESENT_BIT  = 24;
    localparam int MAJOR_LSB    = 16;
    localparam int MINOR_LSB    = 0;
    localparam int ROM_CLR_BIT  = 31;
    localparam int ROM_GO_BIT   = 25;
    localparam int ROM_BYTE_LSB = 16;
    localparam int ROM_EXP_LSB  = 0;
    localparam int DONE_BIT     = 31;
    localparam int LANE_CLR     = 3;
    localparam int LANE_GO      = 3;
    localparam logic [31:0] RETRY_WMASK = 32'h0000_0fff;
    localparam logic [31:0] SEL_WMASK   = 32'h0000_0003;

    // ------------------------------------------------------------------
    // Reset and timeout values
    // ------------------------------------------------------------------
    localparam logic [7:0]  MAJOR_RST  = 8'h01;
    localparam logic [7:0]  MINOR_RST  = 8'h00;
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [7:0]  TMO_BYTE   = 8'hff;
    localparam logic [31:0] RETRY_RST  = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
    localparam logic [31:0] RES_RST [4] = '{32'h0000_003f, 32'h0000_1333,
                                             32'hffff_ffff, 32'hffff_ffff};

    // ------------------------------------------------------------------
    // Timing, bus and state encodings
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int ROM_TIMEOUT_NS  = 5000;
    localparam int ROM_TIMEOUT_CYC = ROM_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [0:0] {
        ROM_IDLE = 1'b0,
        ROM_WAIT = 1'b1
    } hcic_rom_state_t;
endpackage

// >>> hcic_regs.sv
// Identity, retry-limit and compare-swap registers behind AXI4-Lite.
//
// Notes on behaviour
// - Version reads major 01h, minor 00h after reset unless the EEPROM reloads.
// - EEPROM loader may overwrite both version fields, e.g. major 01h minor 10h.
// - Bit 24 of version shows a detected serial EEPROM, else zero.
// - Address-clear bit zeroes the ROM byte address, then clears itself.
// - Read-go bit starts a byte read and clears when the byte arrives or the wait times out.
// - Read-byte field holds the fetched byte; valid only while read-go is zero.
// - Bits 7:0 give the expansion image offset, zero when absent.
// - ROM access bits 30:26, 24 and 15:8 always read zero.
// - Second and cycle limit fields and bits 15:12 read zero.
// - Bits 11:8 hold the physical response retry count.
// - Bits 7:4 and 3:0 hold DMA response and request retries; reset zero.
// - Swap data register holds the value to store on a match; completion loads the prior value.
// - Swap compare register holds the value compared with the resource.
// - Writing the swap control register starts a compare-swap on the selection.
// - Done bit sets on completion, clears on any control write, resets to one.
// - Select 00..11 picks manager ID, bandwidth, channels high, channels low.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module hcic_regs (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    input  wire logic        i_eeprom_detect,
    input  wire logic        i_ver_load,
    input  wire logic [7:0]  i_ver_major,
    input  wire logic [7:0]  i_ver_minor,
    input  wire logic [7:0]  i_exp_offset,
    output logic             o_rom_req,
    output logic [7:0]       o_rom_addr,
    input  wire logic        i_rom_ack,
    input  wire logic [7:0]  i_rom_data,
    output logic [3:0]       o_phys_response_retry_count,
    output logic [3:0]       o_dma_response_retry_count,
    output logic [3:0]       o_dma_request_retry_count
);
    localparam int ROM_WAIT_MAX = hcic_pkg::ROM_TIMEOUT_CYC + 2;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic        awready_reg, wready_reg, bvalid_reg, arready_reg;
    logic        rvalid_reg, aw_hold_reg, w_hold_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg, wmask;
    logic [7:0]  awaddr_reg;
    logic [3:0]  wstrb_reg;
    logic        det_meta_reg, present_reg;
    logic [7:0]  major_reg, minor_reg, exp_off_reg;
    logic        rom_clr_reg, rom_go_reg, rom_req_reg;
    logic [7:0]  rom_addr_reg, rom_byte_reg;
    logic [9:0]  rom_cnt_reg;
    hcic_pkg::hcic_rom_state_t rom_state_reg;
    logic [31:0] retry_reg, swap_new_value_reg, swap_expected_value_reg;
    logic [1:0]  swap_target_select_reg;
    logic        swap_complete_reg, swap_start_reg;
    logic [31:0] res_reg [4];

    // ------------------------------------------------------------------
    // Bus handshake decode
    // ------------------------------------------------------------------
    wire aw_fire = i_awvalid & awready_reg;
    wire w_fire  = i_wvalid & wready_reg;
    wire ar_fire = i_arvalid & arready_reg;
    wire wr_do   = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire aw_hold_next = wr_do ? 1'b0 : (aw_hold_reg | aw_fire);
    wire w_hold_next  = wr_do ? 1'b0 : (w_hold_reg | w_fire);
    wire bvalid_next  = wr_do ? 1'b1 : (bvalid_reg & ~i_bready);

    // Byte-lane mask built once per lane from the held strobes.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask[8*gi +: 8] = {8{wstrb_reg[gi]}};
        end
    endgenerate

    wire wr_ver  = wr_do & (awaddr_reg == hcic_pkg::ADDR_VERSION);
    wire wr_rom  = wr_do & (awaddr_reg == hcic_pkg::ADDR_ROM);
    wire wr_rtry = wr_do & (awaddr_reg == hcic_pkg::ADDR_RETRY);
    wire wr_sdat = wr_do & (awaddr_reg == hcic_pkg::ADDR_SWDATA);
    wire wr_scmp = wr_do & (awaddr_reg == hcic_pkg::ADDR_SWCMP);
    wire wr_sctl = wr_do & (awaddr_reg == hcic_pkg::ADDR_SWCTRL);
    wire wr_hit  = wr_ver | wr_rom | wr_rtry | wr_sdat | wr_scmp | wr_sctl;
    wire go_wr   = wr_rom & wstrb_reg[hcic_pkg::LANE_GO]
                 & wdata_reg[hcic_pkg::ROM_GO_BIT];
    wire clr_wr  = wr_rom & wstrb_reg[hcic_pkg::LANE_CLR]
                 & wdata_reg[hcic_pkg::ROM_CLR_BIT];

    // ------------------------------------------------------------------
    // Read words and read mux
    // ------------------------------------------------------------------
    wire [31:0] ver_word = {7'h00, present_reg, major_reg,
                            8'h00, minor_reg};
    wire [31:0] rom_word = {rom_clr_reg, 5'h00, rom_go_reg, 1'b0,
                            rom_byte_reg, 8'h00, exp_off_reg};
    wire [31:0] rty_word = retry_reg & hcic_pkg::RETRY_WMASK;
    wire [31:0] ctl_word = {swap_complete_reg, 29'h0,
                            swap_target_select_reg};
    wire rd_ver  = (i_araddr == hcic_pkg::ADDR_VERSION);
    wire rd_rom  = (i_araddr == hcic_pkg::ADDR_ROM);
    wire rd_rtry = (i_araddr == hcic_pkg::ADDR_RETRY);
    wire rd_sdat = (i_araddr == hcic_pkg::ADDR_SWDATA);
    wire rd_scmp = (i_araddr == hcic_pkg::ADDR_SWCMP);
    wire rd_sctl = (i_araddr == hcic_pkg::ADDR_SWCTRL);
    wire rd_hit  = rd_ver | rd_rom | rd_rtry | rd_sdat | rd_scmp | rd_sctl;
    wire [31:0] rd_mux = rd_ver  ? ver_word :
                         rd_rom  ? rom_word :
                         rd_rtry ? rty_word :
                         rd_sdat ? swap_new_value_reg :
                         rd_scmp ? swap_expected_value_reg :
                         rd_sctl ? ctl_word : hcic_pkg::WORD_ZERO;

    // ------------------------------------------------------------------
    // Write channels: address and data taken in either order.
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= hcic_pkg::RESP_OKAY;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= hcic_pkg::WORD_ZERO;
            wstrb_reg   <= 4'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg  <= w_hold_next;
            awready_reg <= ~aw_hold_next & ~bvalid_next;
            wready_reg  <= ~w_hold_next & ~bvalid_next;
            bvalid_reg  <= bvalid_next;
            if (aw_fire) begin
                awaddr_reg <= i_awaddr;
            end
            if (w_fire) begin
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
            end
            if (wr_do) begin
                bresp_reg <= wr_hit ? hcic_pkg::RESP_OKAY
                                    : hcic_pkg::RESP_SLVERR;
            end
        end
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= hcic_pkg::WORD_ZERO;
            rresp_reg   <= hcic_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_mux;
            rresp_reg   <= rd_hit ? hcic_pkg::RESP_OKAY
                                  : hcic_pkg::RESP_SLVERR;
        end else begin
            rvalid_reg  <= rvalid_reg & ~i_rready;
            arready_reg <= ~(rvalid_reg & ~i_rready);
        end
    end

    // ------------------------------------------------------------------
    // Version and EEPROM presence
    // ------------------------------------------------------------------
    // The detect pin is asynchronous, so it passes two flops first.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            det_meta_reg <= 1'b0;
            present_reg  <= 1'b0;
            major_reg    <= hcic_pkg::MAJOR_RST;
            minor_reg    <= hcic_pkg::MINOR_RST;
            exp_off_reg  <= 8'h00;
        end else begin
            det_meta_reg <= i_eeprom_detect;
            present_reg  <= det_meta_reg;
            if (i_ver_load) begin
                major_reg   <= i_ver_major;
                minor_reg   <= i_ver_minor;
                exp_off_reg <= i_exp_offset;
            end
        end
    end

    // ------------------------------------------------------------------
    // ROM byte access engine
    // ------------------------------------------------------------------
    // A stalled EEPROM must not hang software, so a timeout ends the wait
    // and returns an all-ones byte.
    wire rom_tmo    = (rom_cnt_reg == 10'(hcic_pkg::ROM_TIMEOUT_CYC));
    wire rom_finish = (rom_state_reg == hcic_pkg::ROM_WAIT)
                    & (i_rom_ack | rom_tmo);
    wire rom_clr_do = rom_clr_reg & (rom_state_reg == hcic_pkg::ROM_IDLE);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rom_state_reg <= hcic_pkg::ROM_IDLE;
            rom_clr_reg   <= 1'b0;
            rom_go_reg    <= 1'b0;
            rom_req_reg   <= 1'b0;
            rom_addr_reg  <= 8'h00;
            rom_byte_reg  <= hcic_pkg::BYTE_RST;
            rom_cnt_reg   <= 10'h000;
        end else begin
            // Clear waits for any read in flight, then self-clears.
            if (rom_clr_do) begin
                rom_clr_reg  <= 1'b0;
                rom_addr_reg <= 8'h00;
            end else if (clr_wr) begin
                rom_clr_reg <= 1'b1;
            end
            case (rom_state_reg)
                hcic_pkg::ROM_IDLE: begin
                    rom_cnt_reg <= 10'h000;
                    if (go_wr && !clr_wr && !rom_clr_reg) begin
                        rom_go_reg    <= 1'b1;
                        rom_req_reg   <= 1'b1;
                        rom_state_reg <= hcic_pkg::ROM_WAIT;
                    end
                end
                hcic_pkg::ROM_WAIT: begin
                    rom_cnt_reg <= rom_cnt_reg + 10'h001;
                    if (rom_finish) begin
                        rom_byte_reg  <= i_rom_ack ? i_rom_data
                                                   : hcic_pkg::TMO_BYTE;
                        rom_go_reg    <= 1'b0;
                        rom_req_reg   <= 1'b0;
                        rom_addr_reg  <= rom_addr_reg + 8'h01;
                        rom_state_reg <= hcic_pkg::ROM_IDLE;
                    end
                end
                default: begin
                    rom_state_reg <= hcic_pkg::ROM_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Retry limits and compare-swap
    // ------------------------------------------------------------------
    wire [31:0] rty_m = hcic_pkg::RETRY_WMASK & wmask;
    wire [31:0] sel_m = hcic_pkg::SEL_WMASK & wmask;
    wire [31:0] prior = res_reg[swap_target_select_reg];
    wire        match = (prior == swap_expected_value_reg);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            retry_reg <= hcic_pkg::RETRY_RST;
        end else if (wr_rtry) begin
            retry_reg <= (retry_reg & ~rty_m) | (wdata_reg & rty_m);
        end
    end

    // Hardware completion takes priority over a software write that lands
    // in the same cycle, so a finished operation is never lost.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            swap_new_value_reg      <= hcic_pkg::WORD_ZERO;
            swap_expected_value_reg <= hcic_pkg::WORD_ZERO;
            swap_target_select_reg  <= 2'b00;
            swap_complete_reg       <= 1'b1;
            swap_start_reg          <= 1'b0;
        end else begin
            swap_start_reg <= wr_sctl;
            if (swap_start_reg) begin
                swap_new_value_reg <= prior;
                swap_complete_reg  <= 1'b1;
            end else begin
                if (wr_sdat) begin
                    swap_new_value_reg <= (swap_new_value_reg & ~wmask)
                                        | (wdata_reg & wmask);
                end
                if (wr_sctl) begin
                    swap_complete_reg <= 1'b0;
                end
            end
            if (wr_scmp) begin
                swap_expected_value_reg <= (swap_expected_value_reg & ~wmask)
                                         | (wdata_reg & wmask);
            end
            if (wr_sctl && !swap_start_reg) begin
                swap_target_select_reg <= (swap_target_select_reg & ~sel_m[1:0])
                                        | (wdata_reg[1:0] & sel_m[1:0]);
            end
        end
    end

    // One flop word per bus-management resource.
    generate
        for (gi = 0; gi < 4; gi++) begin : g_res
            always_ff @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    res_reg[gi] <= hcic_pkg::RES_RST[gi];
                end else if (swap_start_reg && match &&
                             swap_target_select_reg == 2'(gi)) begin
                    res_reg[gi] <= swap_new_value_reg;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_awready = awready_reg;
    assign o_wready  = wready_reg;
    assign o_bvalid  = bvalid_reg;
    assign o_bresp   = bresp_reg;
    assign o_arready = arready_reg;
    assign o_rvalid  = rvalid_reg;
    assign o_rdata   = rdata_reg;
    assign o_rresp   = rresp_reg;
    assign o_rom_req = rom_req_reg;
    assign o_rom_addr = rom_addr_reg;
    assign o_phys_response_retry_count = retry_reg[11:8];
    assign o_dma_response_retry_count  = retry_reg[7:4];
    assign o_dma_request_retry_count   = retry_reg[3:0];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_go_bounded: assert property ($rose(rom_go_reg) |->
        ##[1:ROM_WAIT_MAX] !rom_go_reg)
        else $error("ROM read did not finish in time.");
    a_byte_hold: assert property (rom_go_reg && !rom_finish |=>
        $stable(rom_byte_reg))
        else $error("Read byte changed during a read.");
    a_addr_clear: assert property (rom_clr_do |=>
        (rom_addr_reg == 8'h00) && !rom_clr_reg)
        else $error("Address clear did not complete.");
    a_done_cycle: assert property (wr_sctl |=>
        !swap_complete_reg ##1 swap_complete_reg)
        else $error("Swap done flag sequence wrong.");
    a_swap_store: assert property (swap_start_reg && match |=>
        res_reg[$past(swap_target_select_reg)] == $past(swap_new_value_reg))
        else $error("Swap did not store on match.");
    a_swap_keep: assert property (swap_start_reg && !match |=>
        res_reg[$past(swap_target_select_reg)] == $past(prior))
        else $error("Swap stored on mismatch.");
    a_retry_zero: assert property (ar_fire && rd_rtry |=>
        o_rdata[31:12] == 20'h00000)
        else $error("Retry reserved bits nonzero.");
    a_rom_rsvd: assert property (ar_fire && rd_rom |=>
        (o_rdata[30:26] == 5'h00) && !o_rdata[24] && (o_rdata[15:8] == 8'h00))
        else $error("ROM access reserved bits nonzero.");
    a_present_read: assert property (ar_fire && rd_ver |=>
        o_rdata[hcic_pkg::PRESENT_BIT] == $past(present_reg))
        else $error("EEPROM present flag misreported.");
    a_ver_load: assert property (i_ver_load |=>
        major_reg == $past(i_ver_major) && minor_reg == $past(i_ver_minor))
        else $error("Version load not applied.");

    c_swap_match: cover property (swap_start_reg && match);
    c_rom_ack: cover property (rom_finish && i_rom_ack);
    c_rom_tmo: cover property (rom_finish && rom_tmo);
    c_wr_rd: cover property (wr_rtry ##[1:8] (ar_fire && rd_rtry));
endmodule

// >>> hcic_eeprom_model.sv
// Behavioural serial EEPROM that answers identity byte reads.
`timescale 1ns/10ps
module hcic_eeprom_model #(
    parameter int DELAY = 20
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic       i_mute,
    input  wire logic       i_rom_req,
    input  wire logic [7:0] i_rom_addr,
    output logic            o_rom_ack,
    output logic [7:0]      o_rom_data
);
    int cnt;
    // The answer comes late on purpose, so a busy read can be seen.
    // Between answers the data lines toggle, so a stale byte never matches.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 0;
            o_rom_ack <= 1'b0;
            o_rom_data <= 8'h00;
        // While muted the part never answers, so the host must time out.
        end else if (i_rom_req && !o_rom_ack && cnt == DELAY && !i_mute) begin
            cnt <= 0;
            o_rom_ack <= 1'b1;
            o_rom_data <= i_rom_addr ^ 8'h5a;
        end else begin
            cnt <= (i_rom_req && !o_rom_ack) ? cnt + 1 : 0;
            o_rom_ack <= 1'b0;
            o_rom_data <= ~o_rom_data;
        end
    end
endmodule

// >>> tb.sv
// Self-checking bench for the identity, retry and compare-swap registers.
`timescale 1ns/10ps
module tb;
    logic        i_clk_sys, i_resetn, i_awvalid, i_wvalid, i_bready;
    logic        i_arvalid, i_rready, i_eeprom_detect, i_ver_load;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic        o_rom_req, i_rom_ack, i_mute;
    logic [7:0]  i_awaddr, i_araddr, i_ver_major, i_ver_minor, i_exp_offset;
    logic [7:0]  o_rom_addr, i_rom_data;
    logic [31:0] i_wdata, o_rdata, got;
    logic [3:0]  i_wstrb, o_phys_response_retry_count;
    logic [3:0]  o_dma_response_retry_count, o_dma_request_retry_count;
    logic [1:0]  o_bresp, o_rresp, rsp;
    int          err_count, num_checks, i, n;
    hcic_regs i_hcic_regs (.i_clk_sys, .i_resetn, .i_awaddr, .i_awvalid,
        .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
        .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
        .o_rresp, .o_rvalid, .i_rready, .i_eeprom_detect, .i_ver_load,
        .i_ver_major, .i_ver_minor, .i_exp_offset, .o_rom_req, .o_rom_addr,
        .i_rom_ack, .i_rom_data, .o_phys_response_retry_count,
        .o_dma_response_retry_count, .o_dma_request_retry_count);
    hcic_eeprom_model i_hcic_eeprom_model (.i_clk_sys, .i_resetn, .i_mute,
        .i_rom_req(o_rom_req), .i_rom_addr(o_rom_addr),
        .o_rom_ack(i_rom_ack), .o_rom_data(i_rom_data));
    // Free-running 100 MHz system clock.
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Each channel holds its payload until its own ready is sampled high.
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (n = 0; n < 100 && o_bvalid !== 1'b1; n++) begin
            @(posedge i_clk_sys);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        end
        rsp = o_bresp;
        i_bready <= 1'b0;
        if (n == 100) begin err_count++; report_and_stop(); end
    endtask
    task rd(input logic [7:0] a);
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (n = 0; n < 100 && o_rvalid !== 1'b1; n++) begin
            @(posedge i_clk_sys);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
        end
        got = o_rdata;
        rsp = o_rresp;
        i_rready <= 1'b0;
        if (n == 100) begin err_count++; report_and_stop(); end
    endtask
    // One compare-swap; the prior value comes back in the data register.
    task sw(input logic [1:0] s, input logic [31:0] c, d, prior);
        wr(hcic_pkg::ADDR_SWDATA, d);
        wr(hcic_pkg::ADDR_SWCMP, c);
        wr(hcic_pkg::ADDR_SWCTRL, {30'h0, s});
        rd(hcic_pkg::ADDR_SWCTRL);
        chk("swctrl", got, {1'b1, 29'h0, s});
        rd(hcic_pkg::ADDR_SWDATA);
        chk("swprior", got, prior);
    endtask
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        {i_awaddr, i_araddr, i_wdata, i_wstrb} = {16'h0, 32'h0, 4'hf};
        {i_ver_load, i_ver_major, i_ver_minor, i_exp_offset} = 25'h0;
        i_eeprom_detect = 1'b1;
        i_mute = 1'b0;
        i_resetn = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (12) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        rd(hcic_pkg::ADDR_VERSION);
        chk("version", got, 32'h0101_0000);
        rd(hcic_pkg::ADDR_SWCTRL);
        chk("swreset", got, 32'h8000_0000);
        rd(hcic_pkg::ADDR_RETRY);
        chk("retryrst", got, 32'h0);
        wr(hcic_pkg::ADDR_RETRY, 32'hffff_fa5c);
        chk("wresp", {30'h0, rsp}, {30'h0, hcic_pkg::RESP_OKAY});
        rd(hcic_pkg::ADDR_RETRY);
        chk("retry", got, 32'h0000_0a5c);
        chk("retryout", {20'h0, o_phys_response_retry_count,
            o_dma_response_retry_count, o_dma_request_retry_count},
            32'h0000_0a5c);
        i_ver_load <= 1'b1;
        {i_ver_major, i_ver_minor, i_exp_offset} <= 24'h01_10_20;
        @(posedge i_clk_sys);
        i_ver_load <= 1'b0;
        i_eeprom_detect <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        rd(hcic_pkg::ADDR_VERSION);
        chk("verload", got, 32'h0001_0010);
        // Software only touches the ROM once the present flag reads set.
        i_eeprom_detect <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        rd(hcic_pkg::ADDR_VERSION);
        chk("present", got, 32'h0101_0010);
        wr(hcic_pkg::ADDR_ROM, 32'h8000_0000);
        rd(hcic_pkg::ADDR_ROM);
        chk("romclr", got, 32'h0000_0020);
        // Two reads in a row show the address stepping after a clear.
        for (i = 0; i < 2; i++) begin
            wr(hcic_pkg::ADDR_ROM, 32'h7eff_ff00);
            rd(hcic_pkg::ADDR_ROM);
            chk("rombusy", got, {8'h02, i[0] ? 8'h5a : 8'h00, 16'h20});
            for (int k = 0; k < 20 && got[25] !== 1'b0; k++)
                rd(hcic_pkg::ADDR_ROM);
            chk("romdone", got, {8'h00, 8'h5a ^ i[7:0], 16'h20});
        end
        // A silent EEPROM ends the read by timeout with an all-ones byte.
        i_mute <= 1'b1;
        wr(hcic_pkg::ADDR_ROM, 32'h0200_0000);
        rd(hcic_pkg::ADDR_ROM);
        chk("tmobusy", got, {8'h02, 8'h5b, 16'h20});
        for (int k = 0; k < 200 && got[25] !== 1'b0; k++)
            rd(hcic_pkg::ADDR_ROM);
        chk("romtmo", got, {8'h00, hcic_pkg::TMO_BYTE, 16'h20});
        i_mute <= 1'b0;
        for (i = 0; i < 4; i++) begin
            sw(i[1:0], hcic_pkg::RES_RST[i], 32'h1000 + i, hcic_pkg::RES_RST[i]);
            sw(i[1:0], 32'h0, 32'hdead, 32'h1000 + i);
            sw(i[1:0], 32'h0, 32'h0, 32'h1000 + i);
        end
        wr(8'h40, 32'h1);
        chk("wunmap", {30'h0, rsp}, {30'h0, hcic_pkg::RESP_SLVERR});
        rd(8'h40);
        chk("runmap", got, 32'h0);
        chk("rresp", {30'h0, rsp}, {30'h0, hcic_pkg::RESP_SLVERR});
        report_and_stop();
    end
endmodule
